// [rtl/adc_result_and_channel_select.sv]
`timescale 1ns/1ps
`include "adc_defines.svh"

// What this block does
// - ladder of 1024 steps compared with input gives a 10-bit result
// - writing 0 to reference enable opens the ladder switch
// - scan off: channel field picks one of twelve inputs, 0 to 11
// - scan on: channel field picks one of twelve scan sequences
// - reset clears scan and channel field, so input 0 is selected
// - pins not used as analog channels stay readable as plain inputs
// - result high holds result bits 9..2 in bits 7..0, read-only
// - writing 1 to start begins conversion and sets busy meanwhile
module adc_result_and_channel_select (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  // ahb-lite slave
  input  wire logic                     hsel_in,
  input  wire logic [31:0]              haddr_in,
  input  wire logic [1:0]               htrans_in,
  input  wire logic                     hwrite_in,
  input  wire logic [2:0]               hsize_in,
  input  wire logic [31:0]              hwdata_in,
  input  wire logic                     hready_in,
  output logic      [31:0]              hrdata_out,
  output logic                          hreadyout_out,
  output logic                          hresp_out,
  // analog front end
  input  wire logic                     comparator_in,
  output logic      [`RESULT_W-1:0]     dac_code_out,
  output logic                          sample_out,
  output logic      [3:0]               channel_out,
  output logic      [`NUM_INPUTS-1:0]   analog_select_out,
  output logic                          reference_enable_out,
  // shared pins read as plain inputs
  input  wire logic [`NUM_INPUTS-1:0]   port_pins_in,
  // interrupt
  output logic                          irq_out
);

  // true when an address hits the word of a register index
  function automatic logic reg_hit(input logic [11:0] idx, input logic [11:0] want);
    reg_hit = (idx == want);
  endfunction : reg_hit

  // channel field values above the last input fold onto the last input
  function automatic logic [3:0] chan_limit(input logic [3:0] ch);
    chan_limit = (ch > `LAST_INPUT) ? `LAST_INPUT : ch;
  endfunction : chan_limit

  // ------------------------------------------------------------------
  // bus phase capture
  adc_pkg::ahb_phase_t phase_q, phase_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                addr_take;

  // control state
  logic                scan_q, scan_d;
  logic [3:0]          chan_q, chan_d;
  logic                ref_en_q, ref_en_d;
  logic [8:0]          ref_cnt_q, ref_cnt_d;
  logic [`IRQ_W-1:0]   irq_stat_q, irq_stat_d;
  logic [`IRQ_W-1:0]   irq_mask_q, irq_mask_d;

  // sequencer and results
  adc_pkg::seq_state_t  seq_q, seq_d;
  logic [3:0]           cur_ch_q, cur_ch_d;
  logic                 slot_b_q, slot_b_d;
  logic                 busy_q, busy_d;
  adc_pkg::result_pair_t res_a_q, res_a_d, res_b_q, res_b_d;

  // core hookup
  logic                 core_start;
  logic                 core_done;
  logic [`RESULT_W-1:0] core_result;

  // decoded strobes
  logic                 wr_mode0, wr_mode1, wr_stat, wr_mask;
  logic                 rd_low_a, rd_low_b;
  logic                 start_wr;
  logic                 seq_done;
  logic [3:0]           last_ch;
  logic [`NUM_INPUTS-1:0] sel_mask;

  // an address phase is taken only while the bus is ready
  assign addr_take = hsel_in && htrans_in[1] && hready_in;

  // writes land in the data phase when hwdata is valid
  assign wr_mode0 = phase_q.valid && phase_q.write
                    && reg_hit(phase_q.index, `IDX_MODE_CONTROL_0);
  assign wr_mode1 = phase_q.valid && phase_q.write
                    && reg_hit(phase_q.index, `IDX_MODE_CONTROL_1);
  assign wr_stat  = phase_q.valid && phase_q.write
                    && reg_hit(phase_q.index, `IDX_IRQ_STATUS);
  assign wr_mask  = phase_q.valid && phase_q.write
                    && reg_hit(phase_q.index, `IDX_IRQ_MASK);
  // reads act at the address phase, where the read data is latched
  assign rd_low_a = addr_take && !hwrite_in
                    && reg_hit(haddr_in[13:2], `IDX_RESULT_A_LOW);
  assign rd_low_b = addr_take && !hwrite_in
                    && reg_hit(haddr_in[13:2], `IDX_RESULT_B_LOW);
  // a start request while busy is ignored; the running pass finishes
  assign start_wr = wr_mode0 && hwdata_in[`BIT_START] && !busy_q;

  // ------------------------------------------------------------------
  // read mux, registered so hrdata comes from a flop; zero wait states
  always_comb begin
    rdata_d = 32'h0000_0000;
    phase_d = '0;
    if (addr_take) begin
      phase_d.valid = 1'b1;
      phase_d.write = hwrite_in;
      phase_d.index = haddr_in[13:2];
      if (!hwrite_in) begin
        if (reg_hit(haddr_in[13:2], `IDX_RESULT_A_LOW)) begin
          rdata_d[7:6]         = res_a_q.data[1:0];
          rdata_d[`BIT_STORED] = res_a_q.stored;
        end else if (reg_hit(haddr_in[13:2], `IDX_RESULT_A_HIGH)) begin
          rdata_d[7:0] = res_a_q.data[9:2];
        end else if (reg_hit(haddr_in[13:2], `IDX_RESULT_B_LOW)) begin
          rdata_d[7:6]         = res_b_q.data[1:0];
          rdata_d[`BIT_STORED] = res_b_q.stored;
        end else if (reg_hit(haddr_in[13:2], `IDX_RESULT_B_HIGH)) begin
          rdata_d[7:0] = res_b_q.data[9:2];
        end else if (reg_hit(haddr_in[13:2], `IDX_MODE_CONTROL_0)) begin
          rdata_d[`BIT_SCAN] = scan_q;
          rdata_d[`BIT_BUSY] = busy_q;
        end else if (reg_hit(haddr_in[13:2], `IDX_MODE_CONTROL_1)) begin
          rdata_d[`CH_MSB:0]       = chan_q;
          rdata_d[`BIT_REF_READY]  = ref_en_q && (ref_cnt_q == 9'h000);
          rdata_d[`BIT_REF_ENABLE] = ref_en_q;
        end else if (reg_hit(haddr_in[13:2], `IDX_IRQ_STATUS)) begin
          rdata_d[`IRQ_W-1:0] = irq_stat_q;
        end else if (reg_hit(haddr_in[13:2], `IDX_IRQ_MASK)) begin
          rdata_d[`IRQ_W-1:0] = irq_mask_q;
        end else if (reg_hit(haddr_in[13:2], `IDX_PORT_DATA)) begin
          // analog-selected pins read zero, the rest are plain inputs
          rdata_d[`NUM_INPUTS-1:0] = port_pins_in & ~sel_mask;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phase_q <= '0;
      rdata_q <= 32'h0000_0000;
    end else begin
      phase_q <= phase_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata_out    = rdata_q;
  assign hreadyout_out = 1'b1;  // never stretches a transfer
  assign hresp_out     = 1'b0;  // always okay, unmapped words read zero

  // ------------------------------------------------------------------
  // control registers and reference settle counter
  always_comb begin
    scan_d     = scan_q;
    chan_d     = chan_q;
    ref_en_d   = ref_en_q;
    ref_cnt_d  = ref_cnt_q;
    irq_mask_d = irq_mask_q;
    if (wr_mode0) begin
      scan_d = hwdata_in[`BIT_SCAN];
    end
    if (wr_mode1) begin
      chan_d   = hwdata_in[`CH_MSB:0];
      ref_en_d = hwdata_in[`BIT_REF_ENABLE];  // a 0 opens the ladder switch
    end
    // ready bit only tells software the settle time is over; start is not
    // blocked, since waiting is the caller's duty
    if (!ref_en_q) begin
      ref_cnt_d = 9'(`REF_SETTLE_CYC);
    end else if (ref_cnt_q != 9'h000) begin
      ref_cnt_d = ref_cnt_q - 9'h001;
    end
    if (wr_mask) begin
      irq_mask_d = hwdata_in[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scan_q     <= `SCAN_RESET;
      chan_q     <= `CH_RESET;
      ref_en_q   <= `REF_RESET;
      ref_cnt_q  <= 9'(`REF_SETTLE_CYC);
      irq_mask_q <= `IRQ_MASK_RESET;
    end else begin
      scan_q     <= scan_d;
      chan_q     <= chan_d;
      ref_en_q   <= ref_en_d;
      ref_cnt_q  <= ref_cnt_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  assign reference_enable_out = ref_en_q;

  // ------------------------------------------------------------------
  // channel selection: one pin when fixed, inputs 0..field when scanning
  assign last_ch = chan_limit(chan_q);
  always_comb begin
    sel_mask = '0;
    for (int i = 0; i < `NUM_INPUTS; i++) begin
      if (scan_q) begin
        sel_mask[i] = (4'(i) <= last_ch);
      end else begin
        sel_mask[i] = (4'(i) == last_ch);
      end
    end
  end

  assign analog_select_out = sel_mask;
  assign channel_out       = busy_q ? cur_ch_q : last_ch;

  // ------------------------------------------------------------------
  // conversion sequencer; results alternate between pair a and pair b
  always_comb begin
    seq_d      = seq_q;
    cur_ch_d   = cur_ch_q;
    slot_b_d   = slot_b_q;
    busy_d     = busy_q;
    res_a_d    = res_a_q;
    res_b_d    = res_b_q;
    core_start = 1'b0;
    seq_done   = 1'b0;
    // reading a low register consumes its stored flag
    if (rd_low_a) begin
      res_a_d.stored = 1'b0;
    end
    if (rd_low_b) begin
      res_b_d.stored = 1'b0;
    end
    case (seq_q)
      adc_pkg::SEQ_IDLE: begin
        if (start_wr) begin
          busy_d   = 1'b1;
          // scan bit written with start takes effect now; scan starts at input 0
          cur_ch_d = hwdata_in[`BIT_SCAN] ? 4'h0 : last_ch;
          slot_b_d = 1'b0;
          seq_d    = adc_pkg::SEQ_LOAD;
        end
      end
      adc_pkg::SEQ_LOAD: begin
        core_start = 1'b1;
        seq_d      = adc_pkg::SEQ_WAIT;
      end
      adc_pkg::SEQ_WAIT: begin
        if (core_done) begin
          // a new result sets the flag even if a read clears it this cycle
          if (slot_b_q) begin
            res_b_d.data   = core_result;
            res_b_d.stored = 1'b1;
          end else begin
            res_a_d.data   = core_result;
            res_a_d.stored = 1'b1;
          end
          slot_b_d = !slot_b_q;
          if (scan_q && (cur_ch_q < last_ch)) begin
            cur_ch_d = cur_ch_q + 4'h1;
            seq_d    = adc_pkg::SEQ_LOAD;
          end else begin
            busy_d   = 1'b0;
            seq_done = 1'b1;
            seq_d    = adc_pkg::SEQ_IDLE;
          end
        end
      end
      default: seq_d = adc_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      seq_q          <= adc_pkg::SEQ_IDLE;
      cur_ch_q       <= 4'h0;
      slot_b_q       <= 1'b0;
      busy_q         <= 1'b0;
      res_a_q.stored <= 1'b0;
      res_b_q.stored <= 1'b0;
    end else begin
      seq_q          <= seq_d;
      cur_ch_q       <= cur_ch_d;
      slot_b_q       <= slot_b_d;
      busy_q         <= busy_d;
      res_a_q.stored <= res_a_d.stored;
      res_b_q.stored <= res_b_d.stored;
    end
  end

  // result data has no reset value
  always_ff @(posedge clk_in) begin
    res_a_q.data <= res_a_d.data;
    res_b_q.data <= res_b_d.data;
  end

  // ------------------------------------------------------------------
  // interrupts: sticky, write one to clear, a new event wins over the clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_stat) begin
      irq_stat_d = irq_stat_q & ~hwdata_in[`IRQ_W-1:0];
    end
    if (seq_done) begin
      irq_stat_d[`IRQ_DONE] = 1'b1;
    end
    if (core_done) begin
      irq_stat_d[`IRQ_STORED] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  // ------------------------------------------------------------------
  // successive approximation core, 1024-step ladder search
  sar_core u_sar_core (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .start_in      (core_start),
    .done_out      (core_done),
    .result_out    (core_result),
    .comparator_in (comparator_in),
    .dac_code_out  (dac_code_out),
    .sample_out    (sample_out)
  );

endmodule : adc_result_and_channel_select

// [rtl/adc_defines.svh]
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_RESULT_A_LOW   12'h134
`define IDX_RESULT_A_HIGH  12'h135
`define IDX_RESULT_B_LOW   12'h136
`define IDX_RESULT_B_HIGH  12'h137
`define IDX_MODE_CONTROL_0 12'h138
`define IDX_MODE_CONTROL_1 12'h139
`define IDX_IRQ_STATUS     12'h13A
`define IDX_IRQ_MASK       12'h13B
`define IDX_PORT_DATA      12'h13C

// mode control 0 fields
`define BIT_START          0
`define BIT_SCAN           1
`define BIT_BUSY           7
// mode control 1 fields
`define BIT_REF_ENABLE     7
`define BIT_REF_READY      6
`define CH_MSB             3
// result low fields
`define BIT_STORED         0
`define RES_LOW_MSB        7
// interrupt status fields
`define IRQ_DONE           0
`define IRQ_STORED         1
`define IRQ_W              2

// reset values
`define SCAN_RESET         1'b0
`define CH_RESET           4'h0
`define REF_RESET          1'b0
`define IRQ_MASK_RESET     2'h0

// converter geometry
`define STEPS              1024
`define RESULT_W           10
`define NUM_INPUTS         12
`define LAST_INPUT         4'hB
`define BIT_CYCLES         4'h2

// timing
`define CLK_PERIOD_NS      10
`define REF_SETTLE_US      3
`define REF_SETTLE_CYC     ((`REF_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/adc_pkg.sv]
package adc_pkg;

  // outer sequencer states, gray along idle -> load -> wait
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LOAD = 2'b01,
    SEQ_WAIT = 2'b11
  } seq_state_t;

  // approximation core states
  typedef enum logic [1:0] {
    SAR_IDLE   = 2'b00,
    SAR_SAMPLE = 2'b01,
    SAR_TRIAL  = 2'b11
  } sar_state_t;

  // one result register pair
  typedef struct packed {
    logic [9:0] data;
    logic       stored;
  } result_pair_t;

  // latched ahb address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] index;
  } ahb_phase_t;

endpackage : adc_pkg

// [rtl/sar_core.sv]
`timescale 1ns/1ps
`include "adc_defines.svh"

module sar_core (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // control
  input  wire logic                   start_in,
  output logic                        done_out,
  output logic [`RESULT_W-1:0]        result_out,
  // analog side
  input  wire logic                   comparator_in,
  output logic [`RESULT_W-1:0]        dac_code_out,
  output logic                        sample_out
);

  adc_pkg::sar_state_t  state_q, state_d;
  logic [`RESULT_W-1:0] code_q, code_d;
  logic [3:0]           bit_q, bit_d;
  logic [3:0]           wait_q, wait_d;
  logic                 done_q, done_d;

  // binary search over the ladder, msb first, one bit per trial
  always_comb begin
    state_d = state_q;
    code_d  = code_q;
    bit_d   = bit_q;
    wait_d  = wait_q;
    done_d  = 1'b0;
    case (state_q)
      adc_pkg::SAR_IDLE: begin
        if (start_in) begin
          state_d = adc_pkg::SAR_SAMPLE;
          wait_d  = `BIT_CYCLES;
        end
      end
      adc_pkg::SAR_SAMPLE: begin
        wait_d = wait_q - 4'h1;
        if (wait_q == 4'h1) begin
          state_d = adc_pkg::SAR_TRIAL;
          bit_d   = 4'(`RESULT_W - 1);
          code_d  = {1'b1, {(`RESULT_W-1){1'b0}}};  // first trial at half scale
          wait_d  = `BIT_CYCLES;
        end
      end
      adc_pkg::SAR_TRIAL: begin
        wait_d = wait_q - 4'h1;
        if (wait_q == 4'h1) begin
          // comparator high: input at or above this step, keep the bit
          if (!comparator_in) begin
            code_d[bit_q] = 1'b0;
          end
          wait_d = `BIT_CYCLES;
          if (bit_q == 4'h0) begin
            state_d = adc_pkg::SAR_IDLE;
            done_d  = 1'b1;
          end else begin
            bit_d           = bit_q - 4'h1;
            code_d[bit_d]   = 1'b1;  // next trial bit on
          end
        end
      end
      default: state_d = adc_pkg::SAR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= adc_pkg::SAR_IDLE;
      code_q  <= '0;
      bit_q   <= 4'h0;
      wait_q  <= 4'h0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      code_q  <= code_d;
      bit_q   <= bit_d;
      wait_q  <= wait_d;
      done_q  <= done_d;
    end
  end

  // code holds the final result once done pulses
  assign done_out     = done_q;
  assign result_out   = code_q;
  assign dac_code_out = code_q;
  assign sample_out   = (state_q == adc_pkg::SAR_SAMPLE);

endmodule : sar_core

// [testbench/adc_checker.sv]
`timescale 1ns/1ps
`include "adc_defines.svh"

module adc_checker (
  // clock and reset
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  // bus
  input wire logic                   hsel_in,
  input wire logic [31:0]            haddr_in,
  input wire logic [1:0]             htrans_in,
  input wire logic                   hwrite_in,
  input wire logic [31:0]            hwdata_in,
  input wire logic                   hready_in,
  input wire logic [31:0]            hrdata_out,
  // analog side
  input wire logic                   sample_out,
  input wire logic [`RESULT_W-1:0]   dac_code_out,
  input wire logic [3:0]             channel_out,
  input wire logic [`NUM_INPUTS-1:0] analog_select_out,
  input wire logic                   reference_enable_out
);
  adc_pkg::ahb_phase_t ap_d, ap_q;
  logic                scan_d, scan_q, ref_d, ref_q, seen_d, seen_q, wr_ok, rd_low;
  logic [3:0]          ch_d, ch_q, top;

  // shadow of the control writes; the design applies them at the data-phase edge too
  always_comb begin
    ap_d = '{valid: hsel_in & htrans_in[1] & hready_in, write: hwrite_in, index: haddr_in[13:2]};
    wr_ok = ap_q.valid && ap_q.write;
    {scan_d, ch_d, ref_d} = {scan_q, ch_q, ref_q};
    seen_d = seen_q | sample_out;
    if (wr_ok && ap_q.index == `IDX_MODE_CONTROL_0) scan_d = hwdata_in[`BIT_SCAN];
    if (wr_ok && ap_q.index == `IDX_MODE_CONTROL_1) begin
      ref_d = hwdata_in[`BIT_REF_ENABLE];
      ch_d = hwdata_in[3:0];
    end
    top = (ch_q > 4'hB) ? 4'hB : ch_q;
    rd_low = ap_d.valid && !hwrite_in &&
             (ap_d.index == `IDX_RESULT_A_LOW || ap_d.index == `IDX_RESULT_B_LOW);
  end

  // shadow registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ap_q <= '0;
      {scan_q, ch_q, ref_q, seen_q} <= '0;
    end else begin
      ap_q <= ap_d;
      {scan_q, ch_q, ref_q, seen_q} <= {scan_d, ch_d, ref_d, seen_d};
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_ref; reference_enable_out == ref_q; endproperty
  a_ref: assert property (p_ref) else $error("ladder switch differs from last write");
  property p_fixed; !scan_q |-> analog_select_out == (12'h001 << top); endproperty
  a_fixed: assert property (p_fixed) else $error("fixed select not one-hot");
  property p_scan; scan_q |-> analog_select_out == ((12'h002 << top) - 12'h001); endproperty
  a_scan: assert property (p_scan) else $error("scan select wrong");
  property p_reset;
    $rose(rst_n_in) |-> channel_out == 4'h0 && analog_select_out == 12'h001 &&
                        !reference_enable_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_sample; $rose(sample_out) |-> sample_out[*2] ##1 !sample_out; endproperty
  a_sample: assert property (p_sample) else $error("sampling not two cycles");
  property p_trial; $fell(sample_out) |-> ##[0:2] dac_code_out == 10'h200; endproperty
  a_trial: assert property (p_trial) else $error("first trial not mid ladder");
  property p_low;
    rd_low |=> hrdata_out[31:8] == 24'h00_0000 && hrdata_out[5:1] == 5'h00;
  endproperty
  a_low: assert property (p_low) else $error("unused low bits not zero");
  property p_flag; rd_low && !seen_q |=> !hrdata_out[`BIT_STORED]; endproperty
  a_flag: assert property (p_flag) else $error("stored flag set before conversion");
endmodule : adc_checker

bind adc_result_and_channel_select adc_checker i_chk (.clk_in, .rst_n_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .sample_out, .dac_code_out,
  .channel_out, .analog_select_out, .reference_enable_out);

// [testbench/analog_front.sv]
`timescale 1ns/1ps
`include "adc_defines.svh"

module analog_front (
  // from the converter
  input  wire logic [`RESULT_W-1:0] dac_code_in,
  input  wire logic [3:0]           channel_in,
  input  wire logic                 reference_enable_in,
  // to the converter
  output logic                      comparator_out
);
  logic [`RESULT_W-1:0] level;

  // each pin holds its own level, so a wrong channel shows in the result
  // with the ladder switched off there is no tap voltage, so the comparator never trips
  always_comb begin
    level = 10'h05B + 10'(channel_in) * 10'h04D;
    comparator_out = reference_enable_in && (level >= dac_code_in);
  end
endmodule : analog_front

// [testbench/tb.sv]
`timescale 1ns/1ps
`include "adc_defines.svh"

module tb;
  typedef struct {logic [11:0] idx; logic wr; logic [31:0] wd, mask, exp;} row_t;

  logic        clk_in = 1'b0;
  logic        rst_n_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
  logic        comparator_in, sample_out, reference_enable_out, irq_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd, lo;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic [11:0] port_pins_in, analog_select_out;
  logic [9:0]  dac_code_out;
  logic [3:0]  channel_out;
  int          bad_count, check_count, cycles;
  row_t        rows [8] = '{
    '{`IDX_MODE_CONTROL_0, 1'b0, '0, 32'h0000_0083, '0},
    '{`IDX_MODE_CONTROL_1, 1'b0, '0, 32'h0000_008F, '0},
    '{`IDX_RESULT_A_LOW, 1'b0, '0, 32'hFFFF_FF3F, '0},
    '{`IDX_RESULT_B_LOW, 1'b0, '0, 32'hFFFF_FF3F, '0},
    '{12'h1F0, 1'b1, 32'hFFFF_FFFF, '0, '0},
    '{12'h1F0, 1'b0, '0, 32'hFFFF_FFFF, '0},
    '{`IDX_IRQ_MASK, 1'b1, 32'h0000_0003, '0, '0},
    '{`IDX_PORT_DATA, 1'b0, '0, 32'h0000_0FFE, 32'h0000_0A5A}};

  assign hready_in = hreadyout_out;
  always #5 clk_in = ~clk_in;

  adc_result_and_channel_select i_dut (.clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .comparator_in, .dac_code_out, .sample_out, .channel_out, .analog_select_out,
    .reference_enable_out, .port_pins_in, .irq_out);
  analog_front i_front (.dac_code_in(dac_code_out), .channel_in(channel_out),
    .reference_enable_in(reference_enable_out), .comparator_out(comparator_in));

  // hang guard, well above the longest expected run
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one single ahb transfer; the request holds until hready is seen high
  task automatic bus(input logic [11:0] idx, input logic w, input logic [31:0] wd);
    htrans_in <= 2'b10;
    haddr_in <= {18'h0_0000, idx, 2'b00};
    hwrite_in <= w;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'b00;
    hwdata_in <= wd;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask : bus

  function automatic logic [9:0] lvl(input int c);
    return 10'h05B + 10'(c) * 10'h04D;
  endfunction : lvl

  // start, see busy, then poll until the sequence ends
  task automatic convert(input logic [31:0] mode);
    bus(`IDX_MODE_CONTROL_0, 1'b1, mode | 32'h0000_0001);
    bus(`IDX_MODE_CONTROL_0, 1'b0, '0);
    chk("busy set", 32'h1, 32'(rd[`BIT_BUSY]));
    for (int i = 0; i < 100 && rd[`BIT_BUSY]; i++) bus(`IDX_MODE_CONTROL_0, 1'b0, '0);
    chk("busy clear", 32'h0, 32'(rd[`BIT_BUSY]));
  endtask : convert

  initial begin
    {rst_n_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = '0;
    hsize_in = 3'h2;
    port_pins_in = 12'hA5A;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    hsel_in <= 1'b1;
    @(posedge clk_in);
    foreach (rows[i]) begin
      bus(rows[i].idx, rows[i].wr, rows[i].wd);
      if (!rows[i].wr) chk("register", rows[i].exp, rd & rows[i].mask);
    end
    chk("okay response", 32'h0, 32'(hresp_out));
    $display("test register table done");
    // ladder on, then the settle time before any start
    bus(`IDX_MODE_CONTROL_1, 1'b1, 32'h0000_0080);
    repeat (`REF_SETTLE_CYC) @(posedge clk_in);
    bus(`IDX_MODE_CONTROL_1, 1'b0, '0);
    chk("ladder ready", 32'h0000_00C0, rd);
    for (int c = 0; c < 12; c++) begin
      bus(`IDX_MODE_CONTROL_1, 1'b1, 32'h0000_0080 | 32'(c));
      convert(32'h0000_0000);
      chk("fixed select", 32'(12'h001 << c), 32'(analog_select_out));
      bus(`IDX_RESULT_A_LOW, 1'b0, '0);
      lo = rd;
      bus(`IDX_RESULT_A_HIGH, 1'b0, '0);
      chk("result", 32'(lvl(c)), {22'h0, rd[7:0], lo[7:6]});
      chk("stored flag", 32'h1, 32'(lo[`BIT_STORED]));
      bus(`IDX_RESULT_A_LOW, 1'b0, '0);
      chk("flag after read", 32'h0, 32'(rd[`BIT_STORED]));
    end
    bus(`IDX_MODE_CONTROL_1, 1'b1, 32'h0000_008F);
    @(posedge clk_in);
    chk("clamped select", 32'h0000_0800, 32'(analog_select_out));
    bus(`IDX_RESULT_A_HIGH, 1'b1, 32'h0000_0000);
    bus(`IDX_RESULT_A_HIGH, 1'b0, '0);
    chk("high read only", 32'(lvl(11) >> 2), rd);
    $display("test fixed channels done");
    // scan over inputs 0..2 lands A,B,A; interrupt raised, masked, cleared
    bus(`IDX_IRQ_STATUS, 1'b1, 32'h0000_0003);
    @(posedge clk_in);
    chk("irq cleared", 32'h0, 32'(irq_out));
    bus(`IDX_MODE_CONTROL_1, 1'b1, 32'h0000_0082);
    convert(32'h0000_0002);
    chk("scan select", 32'h0000_0007, 32'(analog_select_out));
    bus(`IDX_RESULT_A_HIGH, 1'b0, '0);
    chk("scan a", 32'(lvl(2) >> 2), rd);
    bus(`IDX_RESULT_B_HIGH, 1'b0, '0);
    chk("scan b", 32'(lvl(1) >> 2), rd);
    chk("irq raised", 32'h1, 32'(irq_out));
    bus(`IDX_IRQ_MASK, 1'b1, 32'h0000_0000);
    @(posedge clk_in);
    chk("irq masked", 32'h0, 32'(irq_out));
    bus(`IDX_IRQ_STATUS, 1'b0, '0);
    chk("irq status", 32'h0000_0003, rd);
    bus(`IDX_IRQ_STATUS, 1'b1, 32'h0000_0003);
    bus(`IDX_IRQ_STATUS, 1'b0, '0);
    chk("status cleared", 32'h0, rd);
    $display("test scan and interrupt done");
    // ladder off, scan field 5 frees pins 6..11 for port use
    bus(`IDX_MODE_CONTROL_1, 1'b1, 32'h0000_0005);
    @(posedge clk_in);
    chk("ladder off", 32'h0, 32'(reference_enable_out));
    chk("scan select", 32'h0000_003F, 32'(analog_select_out));
    bus(`IDX_PORT_DATA, 1'b0, '0);
    chk("port pins", 32'h0000_0A40, rd & 32'h0000_0FC0);
    $display("test ladder and port pins done");
    // reset again in mid-run
    rst_n_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("channel after reset", 32'h0, 32'(channel_out));
    chk("select after reset", 32'h0000_0001, 32'(analog_select_out));
    bus(`IDX_MODE_CONTROL_0, 1'b0, '0);
    chk("scan after reset", 32'h0, rd & 32'h0000_0002);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : tb
